// ### pkg/ddid_pkg.sv
// Constants and types shared by the digital input decoder.
// Assumes a single 200 MHz system clock.
package ddid_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int DEB_TIME_US = 1000;
  localparam int DEB_CYC = DEB_TIME_US * CLK_MHZ;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYC = MS_TIME_US * CLK_MHZ;
  localparam logic [7:0] GATE_MS = 8'h64;
  localparam logic [3:0] GATE_SCALE = 4'hA;
  // ==========================================================
  // Terminals and codes
  localparam int NTERM = 8;
  localparam int FUNC_W = 5;
  localparam int NUM_W = 26;
  localparam logic [2:0] MULTI_SETUP_CODE = 3'h5;
  localparam logic [1:0] REMOTE_PRESET_CODE = 2'h2;
  localparam logic [9:0] PERMILLE_FULL = 10'h3E8;
  localparam logic [4:0] DIV_STEPS = 5'h1A;
  localparam logic [15:0] STEP_MAX = 16'hFFFF;
  // ==========================================================
  // Terminal functions, encoded in declaration order
  typedef enum logic [FUNC_W-1:0] {
    FN_NONE, FN_RESET, FN_COAST_N, FN_RST_COAST_N, FN_START,
    FN_REVERSE, FN_REV_START, FN_DC_HOLD_N, FN_INTERLOCK,
    FN_FRZ_REF, FN_FRZ_OUT, FN_SETUP_LSB, FN_SETUP_MSB,
    FN_PRESET_ON, FN_PRESET_LSB, FN_PRESET_MSB, FN_SPD_DOWN,
    FN_SPD_UP, FN_RUN_PERM, FN_JOG, FN_PROG_LOCK,
    FN_PULSE_REF, FN_PULSE_FB, FN_HAND_START, FN_AUTO_START
  } ddid_func_t;
  typedef enum logic [1:0] {MODE_OFF, MODE_HAND, MODE_AUTO} ddid_mode_t;
endpackage

// ### rtl/ddid_debounce.sv
// Synchroniser and debouncer for one input terminal.
// Assumes the raw level may be asynchronous and bouncy.
`timescale 1ns/1ps
module ddid_debounce
  import ddid_pkg::*;
#(
  parameter int CYCLES = DEB_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw terminal
  input wire logic rawIn,
  // Conditioned levels
  output logic syncOut,
  output logic cleanOut
);
  logic meta_q;
  logic sync_q;
  logic clean_q;
  logic [31:0] cnt_q;

  // ==========================================================
  // Two-stage synchroniser; meta_q feeds only sync_q
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= rawIn;
      sync_q <= meta_q;
    end
  end

  // Level must stay stable for CYCLES before it is taken, so one
  // bouncy edge yields one clean edge (see [RULE_23])
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clean_q <= 1'b0;
      cnt_q <= 32'h0;
    end
    else if (sync_q == clean_q)
      cnt_q <= 32'h0;
    else if (cnt_q >= 32'(CYCLES - 1))
    begin
      clean_q <= sync_q;
      cnt_q <= 32'h0;
    end
    else
      cnt_q <= cnt_q + 32'h1;
  end

  assign syncOut = sync_q;
  assign cleanOut = clean_q;
endmodule

// ### rtl/ddid_decoder.sv
// Digital input decoder: turns programmed terminals into drive commands.
// Assumes one clock; motor control and alarm logic sit downstream.
//
// Functional notes
// [RULE_01] Reset input clears alarms on rising edge
// [RULE_02] Coast input low turns output stage off
// [RULE_03] Reset-coast low coasts, resets on falling edge
// [RULE_04] DC hold low brakes; needs nonzero settings
// [RULE_05] Interlock low coasts and raises external fault
// [RULE_06] Start high runs, low stops
// [RULE_07] Reverse high flips direction; not closed loop
// [RULE_08] Reverse-start runs reversed; no separate start
// [RULE_09] Frozen reference held, changed by speed keys
// [RULE_10] Frozen output holds run; DC hold stops
// [RULE_11] Setup bits select set when multi-setup
// [RULE_12] Preset-on picks preset when remote/preset
// [RULE_13] Preset bits index one of four presets
// [RULE_14] Speed up/down act only while frozen
// [RULE_15] Each pulse steps one tenth unit
// [RULE_16] Start needs any run permissive high
// [RULE_17] Jog runs at jog frequency unless coasting
// [RULE_18] Lock blocks panel writes, bus writes allowed
// [RULE_19] Pulse frequency scales minimum to maximum reference
// [RULE_20] Hand start high runs, low gives off
// [RULE_21] Auto start wins over hand start
// [RULE_22] Terminal hand/auto override panel keys
// [RULE_23] Terminals synchronised and debounced before use; pulse inputs are only synchronised, not debounced
`timescale 1ns/1ps
module ddid_decoder
  import ddid_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYC,
  parameter int MS_CYCLES = MS_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Terminals and programmed functions
  input wire logic [NTERM-1:0] termIn,
  input wire logic [NTERM-1:0][FUNC_W-1:0] termFunc,
  // Configuration
  input wire logic closedLoop,
  input wire logic [2:0] activeSetupCfg,
  input wire logic [1:0] fixedSetup,
  input wire logic [1:0] refTypeCfg,
  input wire logic [7:0] dcBrakeCurrent,
  input wire logic [7:0] dcBrakeTimeMs,
  input wire logic [15:0] rampUpMs,
  input wire logic [15:0] rampDownMs,
  input wire logic [15:0] pulseRefMaxHz,
  // Drive state and panel
  input wire logic alarmTripLocked,
  input wire logic stopKey,
  input wire logic panelHandKey,
  input wire logic panelAutoKey,
  input wire logic panelOffKey,
  input wire logic busStart,
  input wire logic [15:0] presentRef,
  input wire logic [15:0] presentFreq,
  // Alarm and stop commands
  output logic alarmResetPulse_q,
  output logic coastCmd_q,
  output logic dcBrakeCmd_q,
  output logic extFault_q,
  // Run commands
  output logic runCmd_q,
  output logic reverseCmd_q,
  output logic jogCmd_q,
  output ddid_mode_t mode_q,
  // Selections
  output logic [1:0] setupSel_q,
  output logic presetActive_q,
  output logic [1:0] presetIdx_q,
  output logic panelWrEn_q,
  // Frozen values and pulse inputs
  output logic freezeRef_q,
  output logic freezeOut_q,
  output logic [15:0] frozenRef_q,
  output logic [15:0] frozenFreq_q,
  output logic [15:0] pulseRefPermille_q,
  output logic [19:0] pulseFbHz_q
);
  // ==========================================================
  // Terminal conditioning
  logic [NTERM-1:0] syncLvl;
  logic [NTERM-1:0] cleanLvl;

  for (genvar i = 0; i < NTERM; i++)
  begin : g_term
    ddid_debounce #(.CYCLES(DEB_CYCLES)) u_deb (
      .clk(clk),
      .rst(rst),
      .rawIn(termIn[i]),
      .syncOut(syncLvl[i]),
      .cleanOut(cleanLvl[i])
    );
  end

  // {assigned, any high, any low} over terminals carrying function f
  function automatic logic [2:0] fnState(input logic [NTERM-1:0] lvl,
    input logic [NTERM-1:0][FUNC_W-1:0] map, input ddid_func_t f);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < NTERM; i++)
    begin
      if (map[i] == f)
      begin
        s[2] = 1'b1;
        s[1] = s[1] | lvl[i];
        s[0] = s[0] | !lvl[i];
      end
    end
    return s;
  endfunction

  // ==========================================================
  // Function decode
  logic [2:0] sRst, sCoast, sRc, sDc, sIlk, sStart, sRev, sRevSt;
  logic [2:0] sFrzR, sFrzO, sSuL, sSuM, sPrOn, sPrL, sPrM, sDn, sUp;
  logic [2:0] sPerm, sJog, sLock, sHand, sAuto, sPRef, sPFb;
  assign sRst = fnState(cleanLvl, termFunc, FN_RESET);
  assign sCoast = fnState(cleanLvl, termFunc, FN_COAST_N);
  assign sRc = fnState(cleanLvl, termFunc, FN_RST_COAST_N);
  assign sDc = fnState(cleanLvl, termFunc, FN_DC_HOLD_N);
  assign sIlk = fnState(cleanLvl, termFunc, FN_INTERLOCK);
  assign sStart = fnState(cleanLvl, termFunc, FN_START);
  assign sRev = fnState(cleanLvl, termFunc, FN_REVERSE);
  assign sRevSt = fnState(cleanLvl, termFunc, FN_REV_START);
  assign sFrzR = fnState(cleanLvl, termFunc, FN_FRZ_REF);
  assign sFrzO = fnState(cleanLvl, termFunc, FN_FRZ_OUT);
  assign sSuL = fnState(cleanLvl, termFunc, FN_SETUP_LSB);
  assign sSuM = fnState(cleanLvl, termFunc, FN_SETUP_MSB);
  assign sPrOn = fnState(cleanLvl, termFunc, FN_PRESET_ON);
  assign sPrL = fnState(cleanLvl, termFunc, FN_PRESET_LSB);
  assign sPrM = fnState(cleanLvl, termFunc, FN_PRESET_MSB);
  assign sDn = fnState(cleanLvl, termFunc, FN_SPD_DOWN);
  assign sUp = fnState(cleanLvl, termFunc, FN_SPD_UP);
  assign sPerm = fnState(cleanLvl, termFunc, FN_RUN_PERM);
  assign sJog = fnState(cleanLvl, termFunc, FN_JOG);
  assign sLock = fnState(cleanLvl, termFunc, FN_PROG_LOCK);
  assign sHand = fnState(cleanLvl, termFunc, FN_HAND_START);
  assign sAuto = fnState(cleanLvl, termFunc, FN_AUTO_START);
  // Pulse inputs skip the debouncer, which would swallow fast trains
  assign sPRef = fnState(syncLvl, termFunc, FN_PULSE_REF);
  assign sPFb = fnState(syncLvl, termFunc, FN_PULSE_FB);

  // Inverted functions are active when any assigned terminal is low
  logic rcLow, dcLow, ilkLow, coastLow, dcEnable, dcStop;
  assign rcLow = sRc[2] & sRc[0];
  assign dcLow = sDc[2] & sDc[0];
  assign ilkLow = sIlk[2] & sIlk[0];
  assign coastLow = (sCoast[2] & sCoast[0]) | rcLow | ilkLow; // see [RULE_02]
  assign dcEnable = (dcBrakeCurrent != 8'h0) && (dcBrakeTimeMs != 8'h0); // see [RULE_04]
  assign dcStop = dcLow & dcEnable;

  // ==========================================================
  // Edge history
  logic rstPrev_q, rcPrev_q, dcPrev_q, frzRPrev_q, frzOPrev_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rstPrev_q <= 1'b0;
      rcPrev_q <= 1'b0;
      dcPrev_q <= 1'b0;
      frzRPrev_q <= 1'b0;
      frzOPrev_q <= 1'b0;
    end
    else
    begin
      rstPrev_q <= sRst[1];
      rcPrev_q <= rcLow;
      dcPrev_q <= dcLow;
      frzRPrev_q <= sFrzR[1];
      frzOPrev_q <= sFrzO[1];
    end
  end

  // Reset events: rising reset input, falling reset-coast input
  logic resetEvt;
  assign resetEvt = (sRst[1] & !rstPrev_q) | (rcLow & !rcPrev_q); // see [RULE_01] [RULE_03]

  // ==========================================================
  // Millisecond tick for timers and the pulse gate
  logic [31:0] msCnt_q;
  logic msTick;
  assign msTick = (msCnt_q == 32'(MS_CYCLES - 1));
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      msCnt_q <= 32'h0;
    else if (msTick)
      msCnt_q <= 32'h0;
    else
      msCnt_q <= msCnt_q + 32'h1;
  end

  // ==========================================================
  // Alarm, coast and external fault
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      alarmResetPulse_q <= 1'b0;
      coastCmd_q <= 1'b0;
      extFault_q <= 1'b0;
    end
    else
    begin
      // Trip-locked alarms need a power cycle, not a terminal
      alarmResetPulse_q <= resetEvt & !alarmTripLocked; // see [RULE_01]
      coastCmd_q <= coastLow; // see [RULE_02] [RULE_03] [RULE_05]
      // Set wins over a simultaneous clear
      if (ilkLow)
        extFault_q <= 1'b1; // see [RULE_05]
      else if (resetEvt | stopKey)
        extFault_q <= 1'b0;
    end
  end

  // ==========================================================
  // DC hold: brake for the configured time after the input falls
  logic [7:0] dcTimer_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dcTimer_q <= 8'h0;
      dcBrakeCmd_q <= 1'b0;
    end
    else
    begin
      if (dcLow & !dcPrev_q)
        dcTimer_q <= dcBrakeTimeMs;
      else if (msTick && dcTimer_q != 8'h0)
        dcTimer_q <= dcTimer_q - 8'h1;
      dcBrakeCmd_q <= dcStop && (dcTimer_q != 8'h0); // see [RULE_04]
    end
  end

  // ==========================================================
  // Hand / auto / off mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_q <= MODE_AUTO;
    else if (sAuto[1])
      mode_q <= MODE_AUTO; // see [RULE_21]
    else if (sHand[1])
      mode_q <= MODE_HAND; // see [RULE_20]
    else if (sHand[2] | sAuto[2])
      mode_q <= MODE_OFF; // see [RULE_20] [RULE_21] [RULE_22]
    else if (panelAutoKey)
      mode_q <= MODE_AUTO;
    else if (panelHandKey)
      mode_q <= MODE_HAND;
    else if (panelOffKey)
      mode_q <= MODE_OFF;
  end

  // ==========================================================
  // Run, jog and direction
  logic startLvl, permit, demand, frzHold, runNext;
  // Combined reverse-start input is dead in closed loop
  assign startLvl = sStart[1] | (sRevSt[1] & !closedLoop); // see [RULE_06] [RULE_08]
  assign permit = !sPerm[2] | sPerm[1]; // see [RULE_16]
  assign demand = (mode_q == MODE_HAND)
    | ((mode_q == MODE_AUTO) & (startLvl | busStart));
  // Frozen output keeps running whatever the start input does
  assign frzHold = sFrzO[1] & runCmd_q; // see [RULE_10]
  assign runNext = !coastLow & !dcStop & permit
    & ((sJog[1]) | demand | frzHold); // see [RULE_16] [RULE_17]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      runCmd_q <= 1'b0;
      jogCmd_q <= 1'b0;
      reverseCmd_q <= 1'b0;
    end
    else
    begin
      runCmd_q <= runNext; // see [RULE_06]
      jogCmd_q <= sJog[1] & !coastLow; // see [RULE_17]
      reverseCmd_q <= !closedLoop & (sRev[1] | sRevSt[1]); // see [RULE_07] [RULE_08]
    end
  end

  // ==========================================================
  // Setup, preset and programming lock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      setupSel_q <= 2'h0;
      presetActive_q <= 1'b0;
      presetIdx_q <= 2'h0;
      panelWrEn_q <= 1'b1;
    end
    else
    begin
      if (activeSetupCfg == MULTI_SETUP_CODE)
        setupSel_q <= {sSuM[1], sSuL[1]}; // see [RULE_11]
      else
        setupSel_q <= fixedSetup;
      presetActive_q <= (refTypeCfg == REMOTE_PRESET_CODE) & sPrOn[1]; // see [RULE_12]
      presetIdx_q <= {sPrM[1], sPrL[1]}; // see [RULE_13]
      // Only panel writes are gated; the bus path never sees this
      panelWrEn_q <= !sLock[1]; // see [RULE_18]
    end
  end

  // ==========================================================
  // Speed up/down stepping of frozen values
  logic upOnly, dnOnly, upPrev_q, dnPrev_q, frzAny;
  logic [15:0] rampMs_q;
  logic stepUp, stepDn;
  assign upOnly = sUp[1] & !sDn[1];
  assign dnOnly = sDn[1] & !sUp[1];
  assign frzAny = sFrzR[1] | sFrzO[1]; // see [RULE_14]
  // First step on the edge, then one per ramp period while held
  assign stepUp = frzAny & upOnly & ((!upPrev_q)
    | (msTick && rampUpMs != 16'h0 && rampMs_q + 16'h1 >= rampUpMs)); // see [RULE_15]
  assign stepDn = frzAny & dnOnly & ((!dnPrev_q)
    | (msTick && rampDownMs != 16'h0 && rampMs_q + 16'h1 >= rampDownMs)); // see [RULE_15]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      upPrev_q <= 1'b0;
      dnPrev_q <= 1'b0;
      rampMs_q <= 16'h0;
    end
    else
    begin
      upPrev_q <= upOnly;
      dnPrev_q <= dnOnly;
      if (!(upOnly | dnOnly) | stepUp | stepDn)
        rampMs_q <= 16'h0;
      else if (msTick)
        rampMs_q <= rampMs_q + 16'h1;
    end
  end

  // Frozen values survive stop; supply-loss retention is the
  // storage owner's job, fed from these outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      freezeRef_q <= 1'b0;
      freezeOut_q <= 1'b0;
      frozenRef_q <= 16'h0;
      frozenFreq_q <= 16'h0;
    end
    else
    begin
      freezeRef_q <= sFrzR[1];
      freezeOut_q <= sFrzO[1];
      if (sFrzR[1] & !frzRPrev_q)
        frozenRef_q <= presentRef; // see [RULE_09]
      else if (sFrzR[1] & stepUp & frozenRef_q != STEP_MAX)
        frozenRef_q <= frozenRef_q + 16'h1; // see [RULE_14]
      else if (sFrzR[1] & stepDn & frozenRef_q != 16'h0)
        frozenRef_q <= frozenRef_q - 16'h1;
      if (sFrzO[1] & !frzOPrev_q)
        frozenFreq_q <= presentFreq; // see [RULE_10]
      else if (sFrzO[1] & stepUp & frozenFreq_q != STEP_MAX)
        frozenFreq_q <= frozenFreq_q + 16'h1; // see [RULE_14]
      else if (sFrzO[1] & stepDn & frozenFreq_q != 16'h0)
        frozenFreq_q <= frozenFreq_q - 16'h1;
    end
  end

  // ==========================================================
  // Pulse frequency measurement over a fixed gate
  logic refPrev_q, fbPrev_q, gateEnd;
  logic [7:0] gateCnt_q;
  logic [15:0] refCnt_q, fbCnt_q;
  logic [19:0] refHz, refClamp;
  assign gateEnd = msTick && (gateCnt_q == GATE_MS - 8'h1);
  assign refHz = refCnt_q * GATE_SCALE;
  assign refClamp = (refHz > {4'h0, pulseRefMaxHz}) ? {4'h0, pulseRefMaxHz} : refHz;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refPrev_q <= 1'b0;
      fbPrev_q <= 1'b0;
      gateCnt_q <= 8'h0;
      refCnt_q <= 16'h0;
      fbCnt_q <= 16'h0;
      pulseFbHz_q <= 20'h0;
    end
    else
    begin
      refPrev_q <= sPRef[1];
      fbPrev_q <= sPFb[1];
      if (gateEnd)
      begin
        gateCnt_q <= 8'h0;
        refCnt_q <= 16'h0;
        fbCnt_q <= 16'h0;
        pulseFbHz_q <= fbCnt_q * GATE_SCALE;
      end
      else
      begin
        if (msTick)
          gateCnt_q <= gateCnt_q + 8'h1;
        if (sPRef[1] & !refPrev_q & refCnt_q != STEP_MAX)
          refCnt_q <= refCnt_q + 16'h1;
        if (sPFb[1] & !fbPrev_q & fbCnt_q != STEP_MAX)
          fbCnt_q <= fbCnt_q + 16'h1;
      end
    end
  end

  // Serial divider: permille = clamp(f) * 1000 / fmax, slow but small
  logic divBusy_q;
  logic [4:0] divCnt_q;
  logic [NUM_W-1:0] quo_q;
  logic [16:0] rem_q, remS;
  assign remS = {rem_q[15:0], quo_q[NUM_W-1]};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      divBusy_q <= 1'b0;
      divCnt_q <= 5'h0;
      quo_q <= '0;
      rem_q <= 17'h0;
      pulseRefPermille_q <= 16'h0;
    end
    else if (gateEnd)
    begin
      divBusy_q <= (pulseRefMaxHz != 16'h0);
      divCnt_q <= DIV_STEPS;
      quo_q <= NUM_W'(refClamp) * NUM_W'(PERMILLE_FULL); // see [RULE_19]
      rem_q <= 17'h0;
      if (pulseRefMaxHz == 16'h0)
        pulseRefPermille_q <= 16'h0;
    end
    else if (divBusy_q)
    begin
      if (remS >= {1'b0, pulseRefMaxHz})
      begin
        rem_q <= remS - {1'b0, pulseRefMaxHz};
        quo_q <= {quo_q[NUM_W-2:0], 1'b1};
      end
      else
      begin
        rem_q <= remS;
        quo_q <= {quo_q[NUM_W-2:0], 1'b0};
      end
      divCnt_q <= divCnt_q - 5'h1;
      if (divCnt_q == 5'h1)
      begin
        divBusy_q <= 1'b0;
        pulseRefPermille_q <= (remS >= {1'b0, pulseRefMaxHz})
          ? {quo_q[14:0], 1'b1} : {quo_q[14:0], 1'b0}; // see [RULE_19]
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_edge: assert property (sRst[1] && !rstPrev_q && !alarmTripLocked
    |=> alarmResetPulse_q) else $error("reset edge lost"); // see [RULE_01]
  a_trip_lock: assert property (alarmResetPulse_q |-> !$past(alarmTripLocked))
    else $error("trip-locked alarm reset"); // see [RULE_01]
  a_coast_stop: assert property (coastLow |=> coastCmd_q && !runCmd_q && !jogCmd_q)
    else $error("coast did not stop"); // see [RULE_02]
  a_fault_set: assert property (ilkLow |=> extFault_q [*1] ##1 (extFault_q || !$past(ilkLow,1)))
    else $error("interlock fault missing"); // see [RULE_05]
  a_dc_gate: assert property (!dcEnable |=> !dcBrakeCmd_q)
    else $error("dc hold without settings"); // see [RULE_04]
  a_perm_gate: assert property (sPerm[2] && !sPerm[1] |=> !runCmd_q)
    else $error("run without permissive"); // see [RULE_16]
  a_rev_closed: assert property (closedLoop |=> !reverseCmd_q)
    else $error("reverse in closed loop"); // see [RULE_07]
  a_setup_multi: assert property (activeSetupCfg == MULTI_SETUP_CODE
    |=> setupSel_q == $past({sSuM[1], sSuL[1]})) else $error("setup select"); // see [RULE_11]
  a_auto_wins: assert property (sAuto[1] && sHand[1] |=> mode_q == MODE_AUTO)
    else $error("auto lost to hand"); // see [RULE_21]
  a_lock_panel: assert property (sLock[1] |=> !panelWrEn_q)
    else $error("panel write while locked"); // see [RULE_18]

  c_run_start: cover property (!runCmd_q ##1 runCmd_q);
  c_fault_clear: cover property (extFault_q ##1 !extFault_q);
  c_step_up: cover property (stepUp && freezeRef_q);
  c_dc_brake: cover property (dcBrakeCmd_q);
endmodule

// ### verification/ddid_switch_model.sv
// Model of the switches and controller wired to the input terminals.
// Assumes levels change just after a falling clock edge.
`timescale 1ns/1ps
module ddid_switch_model
  import ddid_pkg::*;
#(
  parameter int MS_CYCLES = 10
)(
  // Clock
  input wire logic clk,
  // Terminal levels
  output logic [NTERM-1:0] termIn
);
  // ==========================================================
  // Level and pulse drivers
  // Coast terminal starts closed so the drive is not held coasting
  initial termIn = 8'h02;

  task automatic setLvl(input int idx, input logic v);
    @(negedge clk);
    termIn[idx] = v;
  endtask

  // Shorter speed pulses would be lost, so hold 3 ms each way
  task automatic pulse(input int idx);
    setLvl(idx, 1'h1);
    repeat (3 * MS_CYCLES) @(negedge clk);
    termIn[idx] = 1'h0;
    repeat (3 * MS_CYCLES) @(negedge clk);
  endtask
endmodule

// ### verification/ddid_decoder_tb_top.sv
// Bench for the digital input decoder: terminal tasks and checks.
// Assumes the switch model owns every terminal level.
`timescale 1ns/1ps
module ddid_decoder_tb_top;
  import ddid_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'h0, rst = 1'h1, closedLoop = 1'h0, alarmTripLocked = 1'h0;
  logic stopKey = 1'h0, panelHandKey = 1'h0, panelAutoKey = 1'h0;
  logic panelOffKey = 1'h0, busStart = 1'h0;
  logic [2:0] activeSetupCfg = 3'h0;
  logic [1:0] fixedSetup = 2'h0, refTypeCfg = 2'h0;
  logic [7:0] dcBrakeCurrent = 8'h00, dcBrakeTimeMs = 8'h00;
  logic [15:0] rampUpMs = 16'h0000, rampDownMs = 16'h0000, pulseRefMaxHz = 16'h03E8;
  logic [15:0] presentRef = 16'h0000, presentFreq = 16'h0000;
  logic [NTERM-1:0] termIn;
  logic [NTERM-1:0][FUNC_W-1:0] termFunc = '0;
  logic alarmResetPulse_q, coastCmd_q, dcBrakeCmd_q, extFault_q, runCmd_q;
  logic reverseCmd_q, jogCmd_q, presetActive_q, panelWrEn_q, freezeRef_q, freezeOut_q;
  ddid_mode_t mode_q;
  logic [1:0] setupSel_q, presetIdx_q;
  logic [15:0] frozenRef_q, frozenFreq_q, pulseRefPermille_q;
  logic [19:0] pulseFbHz_q;
  int nErrors = 0, samplesChecked = 0, nPulse = 0, base;

  // Short debounce and tick so the run stays brief
  ddid_decoder #(.DEB_CYCLES(4), .MS_CYCLES(10)) dut (.clk, .rst, .termIn, .termFunc,
    .closedLoop, .activeSetupCfg, .fixedSetup, .refTypeCfg, .dcBrakeCurrent,
    .dcBrakeTimeMs, .rampUpMs, .rampDownMs, .pulseRefMaxHz, .alarmTripLocked, .stopKey,
    .panelHandKey, .panelAutoKey, .panelOffKey, .busStart, .presentRef, .presentFreq,
    .alarmResetPulse_q, .coastCmd_q, .dcBrakeCmd_q, .extFault_q, .runCmd_q,
    .reverseCmd_q, .jogCmd_q, .mode_q, .setupSel_q, .presetActive_q, .presetIdx_q,
    .panelWrEn_q, .freezeRef_q, .freezeOut_q, .frozenRef_q, .frozenFreq_q,
    .pulseRefPermille_q, .pulseFbHz_q);
  ddid_switch_model #(.MS_CYCLES(10)) sw (.clk, .termIn);

  // Clock and reset pulse counter
  always #2.5 clk = ~clk;
  always @(posedge clk) nPulse <= nPulse + int'(alarmResetPulse_q === 1'h1);

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Covers sync, debounce and one output edge with margin
  task automatic settle;
    repeat (12) @(negedge clk);
  endtask

  task automatic drive(input int idx, input logic v);
    sw.setLvl(idx, v);
    settle();
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    // No terminal carries the combined reverse-start, so it never meets START
    termFunc = {FN_PROG_LOCK, FN_RUN_PERM, FN_SETUP_MSB, FN_SETUP_LSB,
      FN_REVERSE, FN_START, FN_COAST_N, FN_RESET};
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'h0;
    chk("mode", mode_q, MODE_AUTO);
    chk("wrEn", panelWrEn_q, 1);
    settle();
    chk("coast", coastCmd_q, 0);
    drive(1, 0);
    chk("coast", coastCmd_q, 1);
    drive(1, 1);
    base = nPulse;
    sw.setLvl(0, 1);
    drive(0, 0);
    chk("glitch", nPulse - base, 0);
    drive(0, 1);
    chk("rstPulse", nPulse - base, 1);
    drive(0, 0);
    alarmTripLocked = 1'h1;
    drive(0, 1);
    chk("locked", nPulse - base, 1);
    alarmTripLocked = 1'h0;
    drive(2, 1);
    chk("noPerm", runCmd_q, 0);
    drive(6, 1);
    chk("run", runCmd_q, 1);
    drive(2, 0);
    chk("stop", runCmd_q, 0);
    busStart = 1'h1;
    settle();
    chk("busRun", runCmd_q, 1);
    busStart = 1'h0;
    drive(3, 1);
    chk("rev", reverseCmd_q, 1);
    closedLoop = 1'h1;
    settle();
    chk("revCl", reverseCmd_q, 0);
    closedLoop = 1'h0;
    activeSetupCfg = MULTI_SETUP_CODE;
    for (int i = 0; i < 4; i++)
    begin
      sw.setLvl(4, i[0]);
      drive(5, i[1]);
      chk("setup", setupSel_q, i[1:0]);
    end
    activeSetupCfg = 3'h0;
    fixedSetup = 2'h2;
    settle();
    chk("fixSetup", setupSel_q, 2);
    drive(7, 1);
    chk("lock", panelWrEn_q, 0);
    drive(7, 0);
    chk("unlock", panelWrEn_q, 1);
    termFunc[1] = FN_INTERLOCK;
    drive(1, 0);
    chk("ilkFlt", extFault_q, 1);
    chk("ilkCoast", coastCmd_q, 1);
    drive(1, 1);
    stopKey = 1'h1;
    settle();
    stopKey = 1'h0;
    chk("fltClr", extFault_q, 0);
    termFunc[3] = FN_DC_HOLD_N;
    dcBrakeCurrent = 8'h10;
    dcBrakeTimeMs = 8'h02;
    drive(3, 0);
    chk("brake", dcBrakeCmd_q, 1);
    repeat (40) @(negedge clk);
    chk("brakeEnd", dcBrakeCmd_q, 0);
    drive(3, 1);
    dcBrakeCurrent = 8'h00;
    drive(3, 0);
    chk("brakeOff", dcBrakeCmd_q, 0);
    termFunc[7:4] = {FN_PRESET_MSB, FN_SETUP_MSB, FN_PRESET_LSB, FN_PRESET_ON};
    refTypeCfg = REMOTE_PRESET_CODE;
    for (int i = 0; i < 4; i++)
    begin
      sw.setLvl(5, i[0]);
      drive(7, i[1]);
      chk("preIdx", presetIdx_q, i[1:0]);
      chk("preOn", presetActive_q, 1);
    end
    drive(4, 0);
    chk("remote", presetActive_q, 0);
    refTypeCfg = 2'h0;
    drive(4, 1);
    chk("noPre", presetActive_q, 0);
    termFunc[7:5] = {FN_AUTO_START, FN_SETUP_MSB, FN_HAND_START};
    // Panel off key must lose to the terminal auto level
    panelOffKey = 1'h1;
    settle();
    chk("auto", mode_q, MODE_AUTO);
    panelOffKey = 1'h0;
    panelAutoKey = 1'h1;
    drive(7, 0);
    chk("hand", mode_q, MODE_HAND);
    panelAutoKey = 1'h0;
    drive(5, 0);
    chk("off", mode_q, MODE_OFF);
    drive(6, 0);
    // Terminal 0 must be low before it turns into a freeze input
    drive(0, 0);
    termFunc[2] = FN_SPD_UP;
    termFunc[6] = FN_SPD_DOWN;
    termFunc[0] = FN_FRZ_REF;
    sw.pulse(2);
    chk("noFrz", frozenRef_q, 0);
    presentRef = 16'h0064;
    drive(0, 1);
    presentRef = 16'h0200;
    chk("frz", frozenRef_q, 16'h0064);
    chk("frzFlag", freezeRef_q, 1);
    sw.pulse(2);
    chk("up", frozenRef_q, 16'h0065);
    sw.pulse(6);
    chk("down", frozenRef_q, 16'h0064);
    termFunc[3] = FN_JOG;
    drive(3, 1);
    chk("jog", jogCmd_q, 1);
    drive(1, 0);
    chk("jogCoast", jogCmd_q, 0);
    report_and_stop();
  end

  // Watchdog well beyond the expected run of about 750 cycles
  initial
  begin
    repeat (8000) @(posedge clk);
    nErrors++;
    report_and_stop();
  end
endmodule
